//--- rtl/atmtx_pkg.sv
// constants, types and helpers for the transmit cell fifo and counter block
package atmtx_pkg;
  localparam int CELL_BYTES = 53;
  localparam int FIFO_CELLS = 4;
  localparam logic [7:0] FIFO_BYTES = 8'(FIFO_CELLS * CELL_BYTES);
  localparam logic [7:0] EARLY_BYTES = 8'h04;
  localparam logic [5:0] LAST_BYTE = 6'(CELL_BYTES - 1);
  localparam logic [5:0] HDR_GFC_BYTE = 6'h00;
  localparam logic [5:0] HDR_PTI_BYTE = 6'h03;
  localparam logic [5:0] HDR_LAST_BYTE = 6'h04;
  localparam int TALLY_W = 19;
  localparam int CLK_MHZ = 25;
  localparam int SNAP_NS = 200;
  localparam int SNAP_CYC = (SNAP_NS * CLK_MHZ + 999) / 1000;
  localparam int SNAP_W = 3;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h60;
  localparam logic [7:0] IDX_IDLE_HDR = 8'h61;
  localparam logic [7:0] IDX_IDLE_PAY = 8'h62;
  localparam logic [7:0] IDX_FIFO_CTL = 8'h63;
  localparam logic [7:0] IDX_CNT_LO = 8'h64;
  localparam logic [7:0] IDX_CNT_MID = 8'h65;
  localparam logic [7:0] IDX_CNT_HI = 8'h66;
  localparam logic [7:0] IDX_CFG = 8'h67;
  localparam logic [7:0] IDX_TEST = 8'h80;
  localparam logic [7:0] RST_IDLE_HDR = 8'h00;
  localparam logic [7:0] RST_IDLE_PAY = 8'h6a;
  localparam logic [7:0] RST_CFG = 8'h08;
  localparam int STAT_IRQ_EN_BIT = 7;
  localparam int STAT_OVF_BIT = 5;
  localparam int FC_THR_LSB = 2;
  localparam int FC_EARLY_BIT = 1;
  localparam int TEST_DFLOAT_BIT = 1;
  localparam int TEST_PFLOAT_BIT = 0;
  localparam logic [6:0] STUFF_COL_A = 7'h1e;
  localparam logic [6:0] STUFF_COL_B = 7'h3b;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [3:0] flow_src;
    logic stuff_en;
    logic ptr_zero;
    logic [1:0] stuff_pat;
  } atmtx_cfg_s;

  typedef enum logic [2:0] {
    SRC_GAP = 3'b001,
    SRC_USER = 3'b010,
    SRC_FILL = 3'b100
  } atmtx_src_e;

  function automatic logic [7:0] thr_bytes(input logic [1:0] code);
    logic [2:0] n;
    n = 3'(FIFO_CELLS) - {1'b0, code};
    return 8'(n * CELL_BYTES);
  endfunction

  function automatic logic [7:0] stuff_value(input logic [1:0] code);
    return {4{code}};
  endfunction
endpackage

//--- rtl/atmtx_tally.sv
// transmitted-cell tally with delayed snapshot
`timescale 1ns/1ps
module atmtx_tally (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic snap_req, // snapshot trigger pulse
  input wire logic cell_done, // user cell finished
  output logic [atmtx_pkg::TALLY_W-1:0] snapshot // held count
);
  localparam logic [atmtx_pkg::TALLY_W-1:0] TALLY_MAX = '1;
  logic [atmtx_pkg::SNAP_W-1:0] wait_cnt;
  logic [atmtx_pkg::TALLY_W-1:0] tally;
  logic fire;

  assign fire = (wait_cnt == atmtx_pkg::SNAP_W'(1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt <= '0;
    end else if (snap_req) begin
      wait_cnt <= atmtx_pkg::SNAP_W'(atmtx_pkg::SNAP_CYC);
    end else if (wait_cnt != '0) begin
      wait_cnt <= wait_cnt - atmtx_pkg::SNAP_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tally <= '0;
    end else if (fire) begin
      tally <= atmtx_pkg::TALLY_W'(cell_done);
    end else if (cell_done && tally != TALLY_MAX) begin
      tally <= tally + atmtx_pkg::TALLY_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snapshot <= '0;
    end else if (fire) begin
      snapshot <= tally;
    end
  end

  a_snap_after_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    snap_req ##1 (!snap_req) [*4] |-> ##2 (snapshot == $past(tally)))
    else $error("snapshot not loaded at the expected edge");
  a_tally_restart_val: assert property (@(posedge aclk) disable iff (!aresetn)
    fire |=> (tally == atmtx_pkg::TALLY_W'($past(cell_done))))
    else $error("tally did not restart at zero or one");
  a_tally_holds_max: assert property (@(posedge aclk) disable iff (!aresetn)
    (tally == TALLY_MAX && !fire) |=> (tally == TALLY_MAX))
    else $error("tally wrapped past its maximum");
endmodule

//--- rtl/atmtx_cell_fifo.sv
// transmit cell fifo, idle cell source, stuff/h4 control and axi4-lite registers
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module atmtx_cell_fifo (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [7:0] tx_cell_byte_bus, // cell byte from writer
  input wire logic tx_cell_byte_valid, // cell byte strobe
  output logic cell_space_flag, // room for more cells
  input wire logic flow_ctl_serial_input, // serial flow control bit
  input wire logic flow_ctl_shift, // serial bit strobe
  input wire logic out_byte_req, // mapper wants a byte
  output logic [7:0] out_byte, // byte to mapper
  output logic out_byte_valid, // out_byte updated
  output logic out_byte_idle, // out_byte is idle cell
  input wire logic sts1_mode, // sts-1 framing
  input wire logic [6:0] stuff_column, // current payload column
  output logic stuff_insert, // insert stuff byte now
  output logic [7:0] stuff_byte, // stuff byte value
  input wire logic [7:0] cell_offset, // cell indicator offset
  output logic [7:0] h4_byte, // h4 byte content
  output logic overflow_irq, // overflow interrupt
  output logic databus_oe, // controller data bus enable
  output logic pins_oe // other pins enable
);
  // fifo storage and pointers
  logic [7:0] mem [0:atmtx_pkg::FIFO_BYTES-1];
  logic [7:0] wr_ptr, rd_ptr, fill;
  logic [5:0] wr_idx, rd_idx;
  logic [2:0] full_cells;
  atmtx_pkg::atmtx_src_e src, next_src;
  // registers
  logic overflow_irq_enable, overflow_flag, early_deassert_select, databus_float, pins_float;
  logic [7:0] idle_hdr, idle_pay;
  logic [1:0] fill_threshold_select;
  atmtx_pkg::atmtx_cfg_s cfg;
  logic [3:0] gfc_serial, gfc_base;
  logic [atmtx_pkg::TALLY_W-1:0] snapshot;
  // bus slave state
  logic aw_held, w_held, aw_ok, wr_lane, do_write, ar_fire, ar_ok;
  logic [7:0] aw_idx, wr_data, ar_idx;
  // datapath helpers
  logic wr_accept, wr_refused, rd_take, cur_user, cell_start, cell_done, snap_req, status_clear;
  logic [7:0] thr, next_byte;

  function automatic logic reg_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    return (addr[11:10] == 2'b00) && (addr[1:0] == 2'b00) &&
           (idx == atmtx_pkg::IDX_GLOBAL || (idx >= atmtx_pkg::IDX_STATUS && idx <= atmtx_pkg::IDX_CFG) ||
            idx == atmtx_pkg::IDX_TEST);
  endfunction

  // ---- axi4-lite slave ----
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[9:2];
  assign ar_ok = reg_mapped(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= 8'h00;
      aw_ok <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx <= s_axi_awaddr[9:2];
      aw_ok <= reg_mapped(s_axi_awaddr);
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wr_data <= 8'h00;
      wr_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata[7:0];
      wr_lane <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= atmtx_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_ok ? atmtx_pkg::RESP_OKAY : atmtx_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_irq_enable <= 1'b0;
      idle_hdr <= atmtx_pkg::RST_IDLE_HDR;
      idle_pay <= atmtx_pkg::RST_IDLE_PAY;
      fill_threshold_select <= 2'b00;
      early_deassert_select <= 1'b0;
      cfg <= atmtx_pkg::RST_CFG;
      databus_float <= 1'b0;
      pins_float <= 1'b0;
    end else if (do_write && aw_ok && wr_lane) begin
      unique case (aw_idx)
        atmtx_pkg::IDX_STATUS: overflow_irq_enable <= wr_data[atmtx_pkg::STAT_IRQ_EN_BIT];
        atmtx_pkg::IDX_IDLE_HDR: idle_hdr <= wr_data;
        atmtx_pkg::IDX_IDLE_PAY: idle_pay <= wr_data;
        atmtx_pkg::IDX_FIFO_CTL: begin
          fill_threshold_select <= wr_data[atmtx_pkg::FC_THR_LSB +: 2];
          early_deassert_select <= wr_data[atmtx_pkg::FC_EARLY_BIT];
        end
        atmtx_pkg::IDX_CFG: cfg <= wr_data;
        atmtx_pkg::IDX_TEST: begin
          databus_float <= wr_data[atmtx_pkg::TEST_DFLOAT_BIT];
          pins_float <= wr_data[atmtx_pkg::TEST_PFLOAT_BIT];
        end
        default: ;
      endcase
    end
  end

  assign snap_req = do_write && aw_ok && (aw_idx == atmtx_pkg::IDX_GLOBAL || aw_idx == atmtx_pkg::IDX_CNT_LO ||
                    aw_idx == atmtx_pkg::IDX_CNT_MID || aw_idx == atmtx_pkg::IDX_CNT_HI);

  // read path; a floated data bus answers slverr with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= atmtx_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (ar_ok && !databus_float) ? atmtx_pkg::RESP_OKAY : atmtx_pkg::RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      if (ar_ok && !databus_float) begin
        unique case (ar_idx)
          atmtx_pkg::IDX_STATUS: begin
            s_axi_rdata[atmtx_pkg::STAT_IRQ_EN_BIT] <= overflow_irq_enable;
            s_axi_rdata[atmtx_pkg::STAT_OVF_BIT] <= overflow_flag;
          end
          atmtx_pkg::IDX_IDLE_HDR: s_axi_rdata[7:0] <= idle_hdr;
          atmtx_pkg::IDX_IDLE_PAY: s_axi_rdata[7:0] <= idle_pay;
          atmtx_pkg::IDX_FIFO_CTL: begin
            s_axi_rdata[atmtx_pkg::FC_THR_LSB +: 2] <= fill_threshold_select;
            s_axi_rdata[atmtx_pkg::FC_EARLY_BIT] <= early_deassert_select;
          end
          atmtx_pkg::IDX_CNT_LO: s_axi_rdata[7:0] <= snapshot[7:0];
          atmtx_pkg::IDX_CNT_MID: s_axi_rdata[7:0] <= snapshot[15:8];
          atmtx_pkg::IDX_CNT_HI: s_axi_rdata[2:0] <= snapshot[18:16];
          atmtx_pkg::IDX_CFG: s_axi_rdata[7:0] <= cfg;
          atmtx_pkg::IDX_TEST: s_axi_rdata[atmtx_pkg::TEST_PFLOAT_BIT] <= pins_float;
          default: ;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---- overflow flag; a new overflow wins over the read clear ----
  assign status_clear = ar_fire && ar_ok && !databus_float && ar_idx == atmtx_pkg::IDX_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
    end else if (wr_refused) begin
      overflow_flag <= 1'b1;
    end else if (status_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  assign overflow_irq = overflow_flag && overflow_irq_enable;

  // ---- fifo write side ----
  assign wr_accept = tx_cell_byte_valid && fill != atmtx_pkg::FIFO_BYTES;
  assign wr_refused = tx_cell_byte_valid && fill == atmtx_pkg::FIFO_BYTES;

  always_ff @(posedge aclk) begin
    if (wr_accept) begin
      mem[wr_ptr] <= tx_cell_byte_bus;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= 8'h00;
      wr_idx <= 6'h00;
    end else if (wr_accept) begin
      wr_ptr <= (wr_ptr == atmtx_pkg::FIFO_BYTES - 8'h01) ? 8'h00 : wr_ptr + 8'h01;
      wr_idx <= (wr_idx == atmtx_pkg::LAST_BYTE) ? 6'h00 : wr_idx + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill <= 8'h00;
    end else begin
      fill <= fill + 8'(wr_accept) - 8'(rd_take);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_cells <= 3'h0;
    end else begin
      full_cells <= full_cells + 3'(wr_accept && wr_idx == atmtx_pkg::LAST_BYTE) - 3'(cell_start);
    end
  end

  // threshold moves only the flag, never the capacity
  assign thr = atmtx_pkg::thr_bytes(fill_threshold_select);
  assign cell_space_flag = early_deassert_select ? (fill < thr - atmtx_pkg::EARLY_BYTES) : (fill < thr);

  // ---- read side: user cell or idle cell ----
  assign cur_user = (src == atmtx_pkg::SRC_USER) || (src == atmtx_pkg::SRC_GAP && full_cells != 3'h0);
  assign cell_start = out_byte_req && src == atmtx_pkg::SRC_GAP && full_cells != 3'h0;
  assign rd_take = out_byte_req && cur_user;
  assign cell_done = rd_take && rd_idx == atmtx_pkg::LAST_BYTE;

  always_comb begin
    next_src = src;
    if (out_byte_req) begin
      if (rd_idx == atmtx_pkg::LAST_BYTE) begin
        next_src = atmtx_pkg::SRC_GAP;
      end else begin
        next_src = cur_user ? atmtx_pkg::SRC_USER : atmtx_pkg::SRC_FILL;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src <= atmtx_pkg::SRC_GAP;
      rd_idx <= 6'h00;
      rd_ptr <= 8'h00;
    end else begin
      src <= next_src;
      if (out_byte_req) begin
        rd_idx <= (rd_idx == atmtx_pkg::LAST_BYTE) ? 6'h00 : rd_idx + 6'h01;
      end
      if (rd_take) begin
        rd_ptr <= (rd_ptr == atmtx_pkg::FIFO_BYTES - 8'h01) ? 8'h00 : rd_ptr + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gfc_serial <= 4'h0;
    end else if (flow_ctl_shift) begin
      gfc_serial <= {gfc_serial[2:0], flow_ctl_serial_input};
    end
  end

  always_comb begin
    gfc_base = cur_user ? mem[rd_ptr][7:4] : idle_hdr[7:4];
    next_byte = 8'h00;
    if (cur_user) begin
      next_byte = mem[rd_ptr];
    end else if (rd_idx == atmtx_pkg::HDR_PTI_BYTE) begin
      next_byte = {4'h0, idle_hdr[3:0]};
    end else if (rd_idx > atmtx_pkg::HDR_LAST_BYTE) begin
      next_byte = idle_pay;
    end
    if (rd_idx == atmtx_pkg::HDR_GFC_BYTE) begin
      next_byte[7:4] = (cfg.flow_src & gfc_serial) | (~cfg.flow_src & gfc_base);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_byte <= 8'h00;
      out_byte_valid <= 1'b0;
      out_byte_idle <= 1'b0;
    end else begin
      out_byte_valid <= out_byte_req;
      if (out_byte_req) begin
        out_byte <= next_byte;
        out_byte_idle <= !cur_user;
      end
    end
  end

  atmtx_tally u_tally (
    .aclk(aclk),
    .aresetn(aresetn),
    .snap_req(snap_req),
    .cell_done(cell_done),
    .snapshot(snapshot)
  );

  // ---- stuff columns, h4 and float enables ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stuff_insert <= 1'b0;
      stuff_byte <= 8'h00;
      h4_byte <= 8'h00;
      databus_oe <= 1'b0;
      pins_oe <= 1'b0;
    end else begin
      stuff_insert <= cfg.stuff_en && sts1_mode &&
                      (stuff_column == atmtx_pkg::STUFF_COL_A || stuff_column == atmtx_pkg::STUFF_COL_B);
      stuff_byte <= atmtx_pkg::stuff_value(cfg.stuff_pat);
      h4_byte <= cfg.ptr_zero ? 8'h00 : cell_offset;
      databus_oe <= !databus_float;
      pins_oe <= !pins_float;
    end
  end

  a_fifo_cap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_cell_byte_valid && fill == atmtx_pkg::FIFO_BYTES && !out_byte_req) |=> (fill == atmtx_pkg::FIFO_BYTES))
    else $error("fifo grew beyond four cells");
  a_ovf_when_full: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(overflow_flag) |-> $past(tx_cell_byte_valid && fill == atmtx_pkg::FIFO_BYTES))
    else $error("overflow raised without a write into a full fifo");
  a_space_flag_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (!early_deassert_select && fill_threshold_select == 2'b11 && fill == 8'h35) |-> !cell_space_flag)
    else $error("cell space flag high at one full cell");
  a_early_deassert: assert property (@(posedge aclk) disable iff (!aresetn)
    (early_deassert_select && fill_threshold_select == 2'b00 && fill == 8'hd0) |-> !cell_space_flag)
    else $error("early deassert missed four bytes before full");
  a_ovf_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_clear && !wr_refused) |=> !overflow_flag ##1 (overflow_flag == $past(wr_refused)))
    else $error("status read did not clear overflow");
  a_idle_no_cell: assert property (@(posedge aclk) disable iff (!aresetn)
    (out_byte_req && src == atmtx_pkg::SRC_GAP && full_cells == 3'h0) |=> out_byte_idle && out_byte_valid)
    else $error("user byte sent with no complete cell");
  a_gfc_serial_src: assert property (@(posedge aclk) disable iff (!aresetn)
    (out_byte_req && rd_idx == 6'h00) |=>
      ((out_byte[7:4] & $past(cfg.flow_src)) == ($past(gfc_serial) & $past(cfg.flow_src))))
    else $error("flow bits not taken from serial input");
  a_stuff_column: assert property (@(posedge aclk) disable iff (!aresetn)
    (sts1_mode && stuff_column == 7'h3b) |=> (stuff_insert == $past(cfg.stuff_en)))
    else $error("stuff column 59 mishandled");
  a_stuff_pattern: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.stuff_pat == 2'b10) [*2] |-> (stuff_byte == 8'haa))
    else $error("stuff pattern 10 not aa");
  a_h4_forced_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.ptr_zero |=> (h4_byte == 8'h00))
    else $error("h4 not zero with pointer byte zero set");
  a_read_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_fire && databus_float) |=> (s_axi_rresp == atmtx_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000))
    else $error("read not blocked while data bus floats");
endmodule

//--- testbench/atmtx_writer.sv
// cell writer model feeding the transmit fifo
`timescale 1ns/1ps
module atmtx_writer (
  input wire logic aclk, // clock
  input wire logic go, // load a byte count
  input wire logic [8:0] n_bytes, // bytes to send
  input wire logic pushy, // start cells without space
  input wire logic cell_space_flag, // room in fifo
  output logic [7:0] tx_cell_byte_bus = 8'h00, // cell byte
  output logic tx_cell_byte_valid = 1'b0, // byte strobe
  output logic busy // bytes still to send
);
  logic [8:0] left = 9'h000;
  logic [5:0] pos = 6'h00;
  logic [7:0] seq = 8'h00;
  assign busy = left != 9'h000;
  // bus toggles between bytes so stale data never repeats
  always @(posedge aclk) begin
    if (!go && busy && (pos != 6'h00 || cell_space_flag || pushy)) begin
      tx_cell_byte_valid <= 1'b1;
      tx_cell_byte_bus <= seq;
      seq <= seq + 8'h01;
      pos <= (pos == 6'h34) ? 6'h00 : pos + 6'h01;
      left <= left - 9'h001;
    end else begin
      tx_cell_byte_valid <= 1'b0;
      tx_cell_byte_bus <= ~tx_cell_byte_bus;
      if (go) begin
        left <= n_bytes;
      end
    end
  end
endmodule

//--- testbench/tb.sv
// self-checking bench for the transmit cell fifo block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rd_d, d;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, go = 1'b0, pushy = 1'b0;
  logic fin = 1'b0, fsh = 1'b0, oreq = 1'b0, sts1 = 1'b0;
  logic [8:0] nb = 9'h000;
  logic [6:0] col = 7'h00;
  logic [7:0] coff = 8'h00, tbyte, ob, sb, h4;
  logic awr, wrdy, bv, arr, rv, tv, csf, obv, obi, sins, irq, doe, poe, busy;
  logic [1:0] br, rr, r;
  logic [3:0] pat = 4'hb;
  logic [7:0] pats [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
  logic [7:0] obq[$];
  int n_fail = 0, checks_done = 0, n_idle = 0;
  atmtx_cell_fifo u_atmtx_cell_fifo (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .tx_cell_byte_bus(tbyte), .tx_cell_byte_valid(tv), .cell_space_flag(csf), .flow_ctl_serial_input(fin),
    .flow_ctl_shift(fsh), .out_byte_req(oreq), .out_byte(ob), .out_byte_valid(obv), .out_byte_idle(obi),
    .sts1_mode(sts1), .stuff_column(col), .stuff_insert(sins), .stuff_byte(sb), .cell_offset(coff),
    .h4_byte(h4), .overflow_irq(irq), .databus_oe(doe), .pins_oe(poe));
  atmtx_writer u_atmtx_writer (.aclk(aclk), .go(go), .n_bytes(nb), .pushy(pushy), .cell_space_flag(csf),
    .tx_cell_byte_bus(tbyte), .tx_cell_byte_valid(tv), .busy(busy));
  always #20 aclk = ~aclk;
  always @(negedge aclk) begin
    if (obv) obq.push_back(ob);
    if (obv && obi) n_idle++;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wrr(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] er);
    logic a, w, b;
    awa <= {2'b00, idx, 2'b00};
    wd <= {24'h000000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(negedge aclk);
      a = awv & awr;
      w = wv & wrdy;
      b = bv;
      r = br;
      @(posedge aclk);
      if (a) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end while (!b);
    `CHK(r, er)
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic a, v;
    ara <= {2'b00, idx, 2'b00};
    arv <= 1'b1;
    do begin
      @(negedge aclk);
      a = arv & arr;
      v = rv;
      d = rd_d;
      r = rr;
      @(posedge aclk);
      if (a) arv <= 1'b0;
    end while (!v);
    `CHK(d, {24'h000000, ed})
    `CHK(r, er)
  endtask
  task automatic send(input logic [8:0] n, input logic ef);
    nb <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(negedge aclk); while (busy);
    @(negedge aclk);
    `CHK(csf, ef)
    @(posedge aclk);
  endtask
  task automatic pull(input int n);
    oreq <= 1'b1;
    repeat (n) @(posedge aclk);
    oreq <= 1'b0;
    @(posedge aclk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h67, 8'h08, 2'b00);
    rc(8'h62, 8'h6a, 2'b00);
    rc(8'h66, 8'h00, 2'b00);
    rc(8'h80, 8'h00, 2'b00);
    rc(8'h70, 8'h00, 2'b10);
    wrr(8'h70, 8'h11, 2'b10);
    $display("registers done");
    for (int c = 3; c >= 0; c--) begin
      wrr(8'h63, 8'(c << 2), 2'b00);
      send(9'(53 * (4 - c) - 1), 1'b1);
      send(9'h001, 1'b0);
      pull(53 * (4 - c));
    end
    for (int i = 0; i < 530; i++) `CHK(obq[i], 8'(i))
    `CHK(n_idle, 0)
    wrr(8'h64, 8'h00, 2'b00);
    repeat (6) @(posedge aclk);
    rc(8'h64, 8'h0a, 2'b00);
    rc(8'h65, 8'h00, 2'b00);
    $display("thresholds done");
    wrr(8'h63, 8'h02, 2'b00);
    wrr(8'h60, 8'h80, 2'b00);
    send(9'h0cf, 1'b1);
    send(9'h001, 1'b0);
    send(9'h004, 1'b0);
    `CHK(irq, 1'b0)
    pushy <= 1'b1;
    send(9'h001, 1'b0);
    `CHK(irq, 1'b1)
    rc(8'h60, 8'ha0, 2'b00);
    rc(8'h60, 8'h80, 2'b00);
    pull(212);
    wrr(8'h00, 8'h00, 2'b00);
    repeat (6) @(posedge aclk);
    rc(8'h64, 8'h04, 2'b00);
    $display("overflow done");
    obq.delete();
    wrr(8'h61, 8'h5b, 2'b00);
    wrr(8'h67, 8'hc8, 2'b00);
    fsh <= 1'b1;
    for (int i = 3; i >= 0; i--) begin
      fin <= pat[i];
      @(posedge aclk);
    end
    fsh <= 1'b0;
    pull(53);
    `CHK(obq[0], 8'h90)
    `CHK(obq[3], 8'h0b)
    `CHK(obq[5], 8'h6a)
    `CHK(n_idle, 53)
    $display("idle cell done");
    sts1 <= 1'b1;
    col <= 7'h1e;
    coff <= 8'h2d;
    for (int c = 0; c < 4; c++) begin
      wrr(8'h67, 8'h08 | 8'(c), 2'b00);
      @(negedge aclk);
      `CHK(sins, 1'b1)
      `CHK(sb, pats[c])
      `CHK(h4, 8'h2d)
      @(posedge aclk);
    end
    col <= 7'h3b;
    wrr(8'h67, 8'h0c, 2'b00);
    @(negedge aclk);
    `CHK(sins, 1'b1)
    `CHK(h4, 8'h00)
    @(posedge aclk);
    sts1 <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    `CHK(sins, 1'b0)
    @(posedge aclk);
    sts1 <= 1'b1;
    wrr(8'h67, 8'h00, 2'b00);
    @(negedge aclk);
    `CHK(sins, 1'b0)
    @(posedge aclk);
    $display("stuff done");
    wrr(8'h80, 8'h02, 2'b00);
    rc(8'h67, 8'h00, 2'b10);
    `CHK(doe, 1'b0)
    `CHK(poe, 1'b1)
    wrr(8'h67, 8'h05, 2'b00);
    wrr(8'h80, 8'h01, 2'b00);
    rc(8'h80, 8'h01, 2'b00);
    rc(8'h67, 8'h05, 2'b00);
    `CHK(doe, 1'b1)
    `CHK(poe, 1'b0)
    $display("float done");
    complete_run;
  end
endmodule
